/* File: hdl/osw_pkg.sv */
// constants and types shared by the serial write decoder
//------------------------------------------------------------------
// Behaviour
// R1: interface select floating gives i2c; driven to either level gives spi-style.
// R2: spi master pulls select low to start and holds it through the last clock.
// R3: i2c transfer opens with slave address 7ah, matched before packet bytes count.
// R4: packets of any length parse as row, column, data; format a repeats all three.
// R5: format b sends column and data pairs that reuse the last row.
// R6: format c treats every byte after the first triple as data, location auto-advances.
// R7: non-data byte with bit 7 set is a row byte, clear is a column byte.
// R8: column bit 6 clear selects format a or b, set selects format c.
// R9: row bit 5 clear targets character-address bytes, set targets attribute bytes.
// R10: character writes join column bit 5 and data byte into a 9-bit font code.
// R11: in format c the latched font bit 8 holds until a new character column byte.
// R12: a to b or c and b to a or c allowed; c never returns.
// R13: master should fill undefined display or font locations with dummy data.
// R14: receive only; no read-back path on the serial interface.
// R15: pixel clock must be an integer multiple of the horizontal sync rate.
// R16: the leading edge of horizontal sync is the timing reference for writes.
// R17: writes reach storage only at sync-aligned points, arbitrated against display reads. Code commits on any cycle with no display read or hsync rise.
// R18: storage covers rows 0 to 14, columns 0 to 29, row control at column 30.
// R19: auto-increment steps the column; after the last column wrap to 0 and next row.
// R20: i2c acknowledges its address and each byte, ignores other addresses.
//------------------------------------------------------------------
package osw_pkg;
	// i2c target address byte, write direction
	localparam logic [7:0] OSW_SLAVE_ADDR = 8'h7A;
	// byte field positions
	localparam int OSW_TYPE_BIT = 7;
	localparam int OSW_AUTO_BIT = 6;
	localparam int OSW_SEL_BIT = 5;
	// display storage geometry
	localparam int OSW_ROWS = 15;
	localparam int OSW_COLS = 31;
	localparam int OSW_LOCS = OSW_ROWS * OSW_COLS;
	localparam logic [4:0] OSW_LAST_COL = 5'h1D;
	localparam logic [4:0] OSW_CTRL_COL = 5'h1E;
	localparam logic [4:0] OSW_LAST_ROW = 5'h0E;
	localparam logic [4:0] OSW_COLS_W = 5'h1F;
	// serial bit counting
	localparam logic [2:0] OSW_SPI_LAST = 3'h7;
	localparam logic [3:0] OSW_I2C_BYTE = 4'h8;
	localparam logic [3:0] OSW_I2C_ACK = 4'h9;
	// reset values
	localparam logic [4:0] OSW_LOC_RST = 5'h00;
	localparam logic [8:0] OSW_DATA_RST = 9'h000;
	typedef enum logic [1:0] {OSW_FMT_A, OSW_FMT_B, OSW_FMT_C} osw_fmt_t;
	typedef enum logic [2:0] {OSW_P_ROW, OSW_P_COL, OSW_P_DATA, OSW_P_NEXT, OSW_P_STREAM} osw_pst_t;
endpackage

/* File: hdl/osw_byte_xfer.sv */
// byte crossing from the serial clock into the pixel clock domain
`timescale 1ns/1ps
`default_nettype none
module osw_byte_xfer
	import osw_pkg::*;
(
	// source side
	input wire logic src_clk,
	input wire logic src_rst_b,
	input wire logic src_load,
	input wire logic [7:0] src_data,
	// destination side
	input wire logic dst_clk,
	input wire logic dst_rst_b,
	output logic dst_valid,
	output logic [7:0] dst_data
);
	logic tgl_q;
	logic [7:0] hold_q;
	logic [2:0] sync_q;
	logic valid_q;
	logic [7:0] data_q;
	wire logic edge_seen;

	// hold stays stable for a whole byte time, far longer than the sync delay
	always_ff @(posedge src_clk or negedge src_rst_b) begin
		if (!src_rst_b) begin
			tgl_q <= 1'b0;
			hold_q <= 8'h00;
		end else if (src_load) begin
			tgl_q <= ~tgl_q;
			hold_q <= src_data;
		end
	end

	// toggle synchroniser; first stage feeds only the second
	always_ff @(posedge dst_clk or negedge dst_rst_b) begin
		if (!dst_rst_b) begin
			sync_q <= 3'b000;
		end else begin
			sync_q <= {sync_q[1:0], tgl_q};
		end
	end

	assign edge_seen = sync_q[2] ^ sync_q[1];

	always_ff @(posedge dst_clk or negedge dst_rst_b) begin
		if (!dst_rst_b) begin
			valid_q <= 1'b0;
			data_q <= 8'h00;
		end else begin
			valid_q <= edge_seen;
			if (edge_seen) begin
				data_q <= hold_q;
			end
		end
	end

	assign dst_valid = valid_q;
	assign dst_data = data_q;
endmodule
`default_nettype wire

/* File: hdl/osw_write_decoder.sv */
// serial write decoder: spi/i2c receive, packet parser and display storage
`timescale 1ns/1ps
`default_nettype none
module osw_write_decoder
	import osw_pkg::*;
(
	// clocks and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic sck,
	// serial pins
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic interface_select_n,
	input wire logic select_driven,
	// display timing and read port
	input wire logic hsync_in,
	input wire logic disp_rd_req,
	input wire logic [4:0] disp_row,
	input wire logic [4:0] disp_col,
	output logic [8:0] disp_char_q,
	output logic [7:0] disp_attr_q,
	// status
	output logic i2c_mode,
	output logic pkt_active,
	output logic [1:0] pkt_format,
	output logic font_code_msb,
	output logic wr_commit,
	output logic wr_overrun,
	output logic hsync_rise
);
	//------------------------------------------------------------------
	// helpers
	//------------------------------------------------------------------
	function automatic logic [8:0] loc_idx(input logic [4:0] row, input logic [4:0] col);
		logic [9:0] prod;
		prod = 10'(row) * 10'(OSW_COLS_W) + 10'(col);
		return prod[8:0];
	endfunction

	function automatic logic loc_ok(input logic [4:0] row, input logic [4:0] col);
		return (row <= OSW_LAST_ROW) && (col <= OSW_CTRL_COL);
	endfunction

	//------------------------------------------------------------------
	// reset release and pin synchronisers
	//------------------------------------------------------------------
	logic [1:0] rst_q;
	logic rst_sync_b;
	logic [4:0] pin_m_q;
	logic [4:0] pin_s_q;
	logic [4:0] pin_d_q;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_q <= 2'b00;
		end else begin
			rst_q <= {rst_q[0], 1'b1};
		end
	end
	assign rst_sync_b = rst_q[1];

	// order: sda, scl, select level, select driven, hsync
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_m_q <= 5'b00000;
			pin_s_q <= 5'b00000;
			pin_d_q <= 5'b00000;
		end else begin
			pin_m_q <= {sda_in, sck, interface_select_n, select_driven, hsync_in};
			pin_s_q <= pin_m_q;
			pin_d_q <= pin_s_q;
		end
	end

	wire logic sda_s = pin_s_q[4];
	wire logic scl_s = pin_s_q[3];
	wire logic scl_rise = pin_s_q[3] & ~pin_d_q[3];
	wire logic scl_fall = ~pin_s_q[3] & pin_d_q[3];
	wire logic i2c_start = scl_s & pin_s_q[3] & pin_d_q[3] & ~sda_s & pin_d_q[4];
	wire logic i2c_stop = scl_s & pin_s_q[3] & pin_d_q[3] & sda_s & ~pin_d_q[4];
	// a floating select pin means i2c; the pad reports whether it is driven
	wire logic mode_i2c = ~pin_s_q[1]; // [R1]
	wire logic spi_act_s = pin_s_q[1] & ~pin_s_q[2]; // [R1]
	wire logic spi_act_d = pin_d_q[1] & ~pin_d_q[2];
	wire logic hs_rise = pin_s_q[0] & ~pin_d_q[0]; // [R16]

	//------------------------------------------------------------------
	// spi receiver on the serial clock
	//------------------------------------------------------------------
	// the frame itself clears the bit count, so a cut frame leaves no residue
	wire logic spi_sel = select_driven & ~interface_select_n; // [R2]
	wire logic spi_rst_b = rst_sync_b & spi_sel;
	logic [2:0] spi_cnt_q;
	logic [6:0] spi_sh_q;
	wire logic spi_load = (spi_cnt_q == OSW_SPI_LAST);
	wire logic [7:0] spi_word = {spi_sh_q, sda_in};
	wire logic spi_v;
	wire logic [7:0] spi_byte;

	always_ff @(posedge sck or negedge spi_rst_b) begin
		if (!spi_rst_b) begin
			spi_cnt_q <= 3'h0;
			spi_sh_q <= 7'h00;
		end else begin
			spi_cnt_q <= spi_cnt_q + 3'h1;
			spi_sh_q <= spi_word[6:0];
		end
	end

	osw_byte_xfer u_xfer (
		.src_clk(sck),
		.src_rst_b(rst_sync_b),
		.src_load(spi_load),
		.src_data(spi_word),
		.dst_clk(clk),
		.dst_rst_b(rst_sync_b),
		.dst_valid(spi_v),
		.dst_data(spi_byte)
	);

	//------------------------------------------------------------------
	// i2c write-only target, oversampled on the system clock
	//------------------------------------------------------------------
	logic i2c_act_q;
	logic addr_ph_q;
	logic addressed_q;
	logic ack_q;
	logic [3:0] bit_q;
	logic [7:0] i2c_sh_q;
	logic i2c_v_q;
	logic [7:0] i2c_byte_q;
	wire logic byte_done = mode_i2c & i2c_act_q & scl_fall & (bit_q == OSW_I2C_BYTE);
	wire logic addr_hit = (i2c_sh_q == OSW_SLAVE_ADDR); // [R3] [R14]

	// ack is only ever a low pull; the target never sends data back
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			i2c_act_q <= 1'b0;
			addr_ph_q <= 1'b0;
			addressed_q <= 1'b0;
			ack_q <= 1'b0;
			bit_q <= 4'h0;
			i2c_sh_q <= 8'h00;
		end else if (!mode_i2c || i2c_stop) begin
			i2c_act_q <= 1'b0;
			addressed_q <= 1'b0;
			ack_q <= 1'b0;
		end else if (i2c_start) begin
			i2c_act_q <= 1'b1;
			addr_ph_q <= 1'b1;
			addressed_q <= 1'b0;
			ack_q <= 1'b0;
			bit_q <= 4'h0;
		end else if (i2c_act_q && scl_rise && bit_q < OSW_I2C_BYTE) begin
			i2c_sh_q <= {i2c_sh_q[6:0], sda_s};
			bit_q <= bit_q + 4'h1;
		end else if (byte_done) begin
			bit_q <= OSW_I2C_ACK;
			if (addr_ph_q) begin
				ack_q <= addr_hit; // [R20]
				addressed_q <= addr_hit;
				i2c_act_q <= addr_hit;
			end else begin
				ack_q <= addressed_q; // [R20]
			end
		end else if (i2c_act_q && scl_fall && bit_q == OSW_I2C_ACK) begin
			ack_q <= 1'b0;
			addr_ph_q <= 1'b0;
			bit_q <= 4'h0;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			i2c_v_q <= 1'b0;
			i2c_byte_q <= 8'h00;
		end else begin
			i2c_v_q <= byte_done & ~addr_ph_q & addressed_q; // [R3]
			if (byte_done) begin
				i2c_byte_q <= i2c_sh_q;
			end
		end
	end

	//------------------------------------------------------------------
	// packet framing and byte source selection
	//------------------------------------------------------------------
	wire logic pkt_begin = mode_i2c ? i2c_start : (spi_act_s & ~spi_act_d);
	wire logic pkt_end = mode_i2c ? i2c_stop : (~spi_act_s & spi_act_d);
	wire logic byte_v = mode_i2c ? i2c_v_q : spi_v;
	wire logic [7:0] byte_in = mode_i2c ? i2c_byte_q : spi_byte;
	wire logic is_row = byte_in[OSW_TYPE_BIT]; // [R7]
	logic pkt_act_q;

	// end of frame does not reset the parser: a late crossed byte still lands
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pkt_act_q <= 1'b0;
		end else if (pkt_begin) begin
			pkt_act_q <= 1'b1;
		end else if (pkt_end) begin
			pkt_act_q <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// packet parser
	//------------------------------------------------------------------
	osw_pst_t pst_q;
	osw_pst_t pst_d;
	osw_fmt_t fmt_q;
	osw_fmt_t fmt_d;
	logic [4:0] row_q;
	logic [4:0] col_q;
	logic attr_q;
	logic msb_q;
	logic auto_q;
	wire logic [4:0] row_new = byte_in[OSW_SEL_BIT] ? byte_in[4:0] : {1'b0, byte_in[3:0]};
	wire logic col_step = byte_v & ((pst_q == OSW_P_COL) | (pst_q == OSW_P_NEXT)) & ~is_row;
	wire logic row_step = byte_v & (pst_q != OSW_P_STREAM) & (pst_q != OSW_P_DATA) & is_row;
	wire logic data_step = byte_v & ((pst_q == OSW_P_DATA) | (pst_q == OSW_P_STREAM)); // [R4]
	wire logic last_col = (col_q == OSW_LAST_COL);
	wire logic [4:0] col_inc = last_col ? OSW_LOC_RST : col_q + 5'h01; // [R19]
	wire logic [4:0] row_inc = !last_col ? row_q :
		(row_q == OSW_LAST_ROW) ? OSW_LOC_RST : row_q + 5'h01; // [R19]

	// once streaming, only a new packet leaves it
	always_comb begin
		pst_d = pst_q;
		fmt_d = fmt_q;
		unique case (pst_q)
			OSW_P_ROW: if (byte_v && is_row) pst_d = OSW_P_COL;
			OSW_P_COL: if (byte_v && !is_row) pst_d = OSW_P_DATA;
			OSW_P_DATA: if (byte_v) pst_d = auto_q ? OSW_P_STREAM : OSW_P_NEXT; // [R8]
			OSW_P_NEXT: begin
				if (byte_v) begin
					pst_d = is_row ? OSW_P_COL : OSW_P_DATA;
					fmt_d = is_row ? OSW_FMT_A : OSW_FMT_B; // [R5] [R12]
				end
			end
			OSW_P_STREAM: pst_d = OSW_P_STREAM; // [R6] [R12]
		endcase
		if (col_step && byte_in[OSW_AUTO_BIT]) begin
			fmt_d = OSW_FMT_C; // [R8]
		end
		if (pkt_begin) begin
			pst_d = OSW_P_ROW;
			fmt_d = OSW_FMT_A;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pst_q <= OSW_P_ROW;
			fmt_q <= OSW_FMT_A;
		end else begin
			pst_q <= pst_d;
			fmt_q <= fmt_d;
		end
	end

	// location, target and font bank
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			row_q <= OSW_LOC_RST;
			col_q <= OSW_LOC_RST;
			attr_q <= 1'b0;
			msb_q <= 1'b0;
			auto_q <= 1'b0;
		end else if (row_step) begin
			row_q <= row_new;
			attr_q <= byte_in[OSW_SEL_BIT]; // [R9]
		end else if (col_step) begin
			col_q <= byte_in[4:0];
			auto_q <= byte_in[OSW_AUTO_BIT]; // [R8]
			if (!attr_q) begin
				msb_q <= byte_in[OSW_SEL_BIT]; // [R10] [R11]
			end
		end else if (data_step && auto_q) begin
			col_q <= col_inc; // [R6] [R19]
			row_q <= row_inc;
		end
	end

	//------------------------------------------------------------------
	// write holding register and arbitration
	//------------------------------------------------------------------
	// one word only: a write not yet committed is overwritten and flagged
	logic pend_q;
	logic [4:0] wr_row_q;
	logic [4:0] wr_col_q;
	logic wr_attr_q;
	logic [8:0] wr_data_q;
	logic ovr_q;
	wire logic commit = pend_q & ~disp_rd_req & ~hs_rise; // [R16] [R17]
	wire logic [8:0] wr_word = attr_q ? {1'b0, byte_in} : {msb_q, byte_in}; // [R10]

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pend_q <= 1'b0;
			wr_row_q <= OSW_LOC_RST;
			wr_col_q <= OSW_LOC_RST;
			wr_attr_q <= 1'b0;
			wr_data_q <= OSW_DATA_RST;
		end else if (data_step) begin
			pend_q <= 1'b1;
			wr_row_q <= row_q;
			wr_col_q <= col_q;
			wr_attr_q <= attr_q;
			wr_data_q <= wr_word;
		end else if (commit) begin
			pend_q <= 1'b0;
		end
	end

	// a new loss beats the clear from the next packet start
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ovr_q <= 1'b0;
		end else if (data_step && pend_q && !commit) begin
			ovr_q <= 1'b1;
		end else if (pkt_begin) begin
			ovr_q <= 1'b0;
		end
	end

	//------------------------------------------------------------------
	// display storage
	//------------------------------------------------------------------
	// out-of-range locations (rows beyond 14, column 31) are dropped here
	logic [8:0] char_mem [OSW_LOCS];
	logic [7:0] attr_mem [OSW_LOCS];
	logic commit_q;
	wire logic [8:0] wr_idx = loc_idx(wr_row_q, wr_col_q);
	wire logic [8:0] rd_idx = loc_idx(disp_row, disp_col);
	wire logic wr_ok = commit & loc_ok(wr_row_q, wr_col_q); // [R18]
	wire logic rd_ok = loc_ok(disp_row, disp_col);

	always_ff @(posedge clk) begin
		if (wr_ok && wr_attr_q) begin
			attr_mem[wr_idx] <= wr_data_q[7:0];
		end
		if (wr_ok && !wr_attr_q) begin
			char_mem[wr_idx] <= wr_data_q;
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			disp_char_q <= OSW_DATA_RST;
			disp_attr_q <= 8'h00;
			commit_q <= 1'b0;
		end else begin
			commit_q <= commit;
			if (disp_rd_req) begin
				disp_char_q <= rd_ok ? char_mem[rd_idx] : OSW_DATA_RST;
				disp_attr_q <= rd_ok ? attr_mem[rd_idx] : 8'h00;
			end
		end
	end

	//------------------------------------------------------------------
	// outputs
	//------------------------------------------------------------------
	assign sda_out = 1'b0;
	assign sda_oe = ack_q; // [R14]
	assign i2c_mode = mode_i2c;
	assign pkt_active = pkt_act_q;
	assign pkt_format = fmt_q;
	assign font_code_msb = msb_q;
	assign wr_commit = commit_q;
	assign wr_overrun = ovr_q;
	assign hsync_rise = hs_rise;

	//------------------------------------------------------------------
	// checks
	//------------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_sync_b);

	spi_no_drive_a: assert property (!mode_i2c |-> ##1 !sda_oe) else $error("sda driven in spi mode"); // [R1]
	addr_ack_a: assert property (byte_done && addr_ph_q && !addr_hit |=> !ack_q) else $error("ack on foreign address"); // [R20]
	addr_match_a: assert property ($rose(ack_q) && addr_ph_q |-> $past(i2c_sh_q) == OSW_SLAVE_ADDR) else $error("address ack without match"); // [R3]
	row_byte_a: assert property (byte_v && is_row && pst_q == OSW_P_COL && !pkt_begin |=> pst_q == OSW_P_COL && row_q == $past(row_new)) else $error("row byte misclassified"); // [R7]
	auto_enter_a: assert property (data_step && pst_q == OSW_P_DATA && auto_q && !pkt_begin |=> pst_q == OSW_P_STREAM && fmt_q == OSW_FMT_C) else $error("stream not entered"); // [R8]
	fmt_lock_a: assert property (fmt_q == OSW_FMT_C && !pkt_begin |=> fmt_q == OSW_FMT_C) else $error("left format c"); // [R12]
	row_reuse_a: assert property (col_step && pst_q == OSW_P_NEXT && !pkt_begin |=> pst_q == OSW_P_DATA && $stable(row_q)) else $error("row not reused"); // [R5]
	font_bit_a: assert property (col_step && !attr_q |=> msb_q == $past(byte_in[OSW_SEL_BIT])) else $error("font bit 8 not latched"); // [R10]
	bank_hold_a: assert property (pst_q == OSW_P_STREAM && !pkt_begin |=> $stable(msb_q)) else $error("font bank changed in stream"); // [R11]
	col_wrap_a: assert property (data_step && auto_q && pst_q == OSW_P_STREAM && last_col |=> col_q == OSW_LOC_RST) else $error("column did not wrap"); // [R19]
	commit_gate_a: assert property (pend_q && (disp_rd_req || hs_rise) |=> pend_q && !wr_commit) else $error("write not held back"); // [R17]
	data_latch_a: assert property (data_step |=> pend_q && wr_row_q == $past(row_q) && wr_col_q == $past(col_q)) else $error("data byte not held"); // [R4]
endmodule
`default_nettype wire

/* File: tb/osw_mcu_model.sv */
// microcontroller model: write-only spi or i2c master for the decoder
`timescale 1ns/1ps
`default_nettype none
module osw_mcu_model (
	// pins toward the decoder
	output logic sck,
	output logic sda_m,
	output logic interface_select_n,
	output logic select_driven,
	// resolved data line
	input wire logic sda_line
);
	// ------------------------------------------------------------
	// idle pins: released lines sit at their pull-up level
	// ------------------------------------------------------------
	initial begin
		sck = 1'b1;
		sda_m = 1'b1;
		interface_select_n = 1'b1;
		select_driven = 1'b1;
	end
	// select low well before the first edge, sck stands still outside frames
	task automatic spi_begin();
		select_driven = 1'b1;
		interface_select_n = 1'b0;
		#200;
	endtask
	// msb first, data changed while sck is low, 125 ns period
	task automatic spi_byte(input logic [7:0] b);
		for (int i = 7; i >= 0; i--) begin
			sck = 1'b0;
			sda_m = b[i];
			#62.5;
			sck = 1'b1;
			#62.5;
		end
	endtask
	// select held past the last rising edge of the packet
	task automatic spi_end();
		#100;
		interface_select_n = 1'b1;
		sda_m = 1'b1;
		#400;
	endtask
	// floating select; sda falls while scl is high
	task automatic i2c_start();
		select_driven = 1'b0;
		#200;
		sda_m = 1'b0;
		#250;
		sck = 1'b0;
	endtask
	// eight bits then a released ninth bit; sda moves only well after scl falls
	task automatic i2c_byte(input logic [7:0] b, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			#50;
			sda_m = (i == 0) ? 1'b1 : b[i-1];
			#200;
			sck = 1'b1;
			ack = ~sda_line;
			#250;
			sck = 1'b0;
		end
	endtask
	task automatic i2c_stop();
		#50;
		sda_m = 1'b0;
		#200;
		sck = 1'b1;
		#250;
		sda_m = 1'b1;
		#250;
	endtask
endmodule
`default_nettype wire

/* File: tb/tb_osd_serial_write_decoder.sv */
// self-checking bench for the serial write decoder
`timescale 1ns/1ps
`default_nettype none
module tb_osd_serial_write_decoder import osw_pkg::*;;
	// ------------------------------------------------------------
	// clocks, pins and counters
	// ------------------------------------------------------------
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	wire sck, sda_m, sel_n, sel_drv, sda_line;
	logic sda_out, sda_oe, hsync_in, rd_req, i2c_mode, pkt_active, fmsb, wr_commit;
	logic wr_overrun, hsync_rise, use_i2c, exp_ack, ack;
	logic [4:0] rd_row, rd_col;
	logic [8:0] char_q, ex_c [15][31];
	logic [7:0] attr_q, ex_a [15][31];
	logic [1:0] pkt_format;
	logic [10:0] rq [$];
	int error_cnt = 0, checks = 0, n_wr = 0, n_commit = 0;
	integer seed = 32'he08c;
	always #10 clk = ~clk; // hsync is moved on whole clock cycles only
	// pull-up on sda; the decoder can only pull it low
	assign sda_line = sda_m & ~(sda_oe & ~sda_out);
	always @(negedge clk) if (wr_commit === 1'b1) n_commit++;
	osw_mcu_model mcu (.sck(sck), .sda_m(sda_m), .interface_select_n(sel_n),
		.select_driven(sel_drv), .sda_line(sda_line));
	osw_write_decoder dut (.clk(clk), .rst_b(rst_b), .sck(sck), .sda_in(sda_line),
		.sda_out(sda_out), .sda_oe(sda_oe), .interface_select_n(sel_n),
		.select_driven(sel_drv), .hsync_in(hsync_in), .disp_rd_req(rd_req),
		.disp_row(rd_row), .disp_col(rd_col), .disp_char_q(char_q), .disp_attr_q(attr_q),
		.i2c_mode(i2c_mode), .pkt_active(pkt_active), .pkt_format(pkt_format),
		.font_code_msb(fmsb), .wr_commit(wr_commit), .wr_overrun(wr_overrun),
		.hsync_rise(hsync_rise));
	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wrap_up();
		$display("checks=%0d error_cnt=%0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	// next streaming location: wrap after the last column, row 14 back to 0
	function automatic logic [9:0] nxt(input logic [9:0] rc);
		if (rc[4:0] == OSW_LAST_COL) return {(rc[9:5] == OSW_LAST_ROW) ? 5'h00 : rc[9:5] + 5'h01, 5'h00};
		return rc + 10'h001;
	endfunction
	// expected storage only moves when the target is meant to accept
	task automatic put(input bit a, input logic [4:0] r, c, input bit d8, input logic [7:0] d);
		if (exp_ack) begin
			if (a) ex_a[r][c] = d;
			else ex_c[r][c] = {d8, d};
			n_wr++;
			rq.push_back({a, r, c});
		end
	endtask
	task automatic sb(input logic [7:0] b);
		if (use_i2c) begin
			mcu.i2c_byte(b, ack);
			chk(ack, exp_ack);
		end else mcu.spi_byte(b);
	endtask
	task automatic tri_w(input bit a, rw, au, d8, input logic [4:0] r, c, input logic [7:0] d);
		if (rw) sb({2'b10, a, r});
		sb({1'b0, au, d8, c});
		sb(d);
		put(a, r, c, d8, d);
	endtask
	// read back every written place, one low cycle between requests
	task automatic rb();
		logic [10:0] e;
		while (rq.size() > 0) begin
			e = rq.pop_front();
			@(negedge clk);
			rd_req = 1'b1;
			{rd_row, rd_col} = e[9:0];
			@(negedge clk);
			rd_req = 1'b0;
			if (e[10]) chk(attr_q, ex_a[e[9:5]][e[4:0]]);
			else chk(char_q, ex_c[e[9:5]][e[4:0]]);
		end
		chk(n_commit, n_wr);
		chk(wr_overrun, 1'b0);
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_hs();
		int n;
		n = 0;
		@(negedge clk);
		hsync_in = 1'b1;
		for (int k = 0; k < 12; k++) begin
			@(negedge clk);
			n += (hsync_rise === 1'b1);
			if (k == 5) hsync_in = 1'b0;
		end
		chk(n, 1);
		$display("hsync test done");
	endtask
	// random mix of full triples and row-reusing pairs in one packet
	task automatic t_ab();
		bit rw, a;
		logic [4:0] r;
		mcu.spi_begin();
		for (int k = 0; k < 8; k++) begin
			rw = (k == 0) ? 1'b1 : 1'($random(seed));
			// a pair without a row byte stays in the bank of the last row
			if (rw) begin
				r = 5'({$random(seed)} % 15);
				a = 1'($random(seed));
			end
			tri_w(a, rw, 1'b0, 1'($random(seed)), r, 5'({$random(seed)} % 31),
				8'($random(seed)));
		end
		mcu.spi_end();
		chk(pkt_format, rw ? OSW_FMT_A : OSW_FMT_B);
		chk(sda_oe, 1'b0);
		rb();
		$display("format a/b test done");
	endtask
	// streaming across the row end; a byte with bit 7 set stays data
	task automatic t_c(input bit a, input logic [4:0] r0, c0);
		logic [9:0] rc;
		logic [7:0] d;
		bit d8;
		rc = {r0, c0};
		d8 = $random(seed);
		mcu.spi_begin();
		chk(pkt_active, 1'b1);
		sb({2'b10, a, 5'h02}); // a second row byte replaces this one
		tri_w(a, 1'b1, 1'b1, d8, r0, c0, $random(seed));
		for (int k = 0; k < 5; k++) begin
			d = (k == 1) ? 8'h85 : 8'($random(seed));
			rc = nxt(rc);
			sb(d);
			put(a, rc[9:5], rc[4:0], d8, d);
		end
		mcu.spi_end();
		chk(pkt_active, 1'b0);
		chk(pkt_format, OSW_FMT_C);
		if (!a) chk(fmsb, d8);
		rb();
		$display("format c test done");
	endtask
	// display reads hold a write back; row control column accepted
	task automatic t_hold();
		int n0;
		@(negedge clk);
		rd_req = 1'b1;
		rd_row = 5'h0F;
		rd_col = 5'h00;
		n0 = n_commit;
		mcu.spi_begin();
		tri_w(1'b1, 1'b1, 1'b0, 1'b0, 5'h03, OSW_CTRL_COL, 8'h03);
		mcu.spi_end();
		chk(n_commit - n0, 0);
		chk(char_q, 9'h000);
		chk(attr_q, 8'h00);
		@(negedge clk);
		rd_req = 1'b0;
		repeat (4) @(negedge clk);
		rb();
		$display("commit hold test done");
	endtask
	// matching address acked and stored; others ignored until next start
	task automatic t_i2c();
		logic [7:0] bad [3] = '{8'h7B, 8'h7C, 8'h3D};
		logic [4:0] r, c;
		r = 5'({$random(seed)} % 15);
		c = 5'({$random(seed)} % 31);
		use_i2c = 1'b1;
		mcu.i2c_start();
		chk(i2c_mode, 1'b1);
		mcu.i2c_byte(OSW_SLAVE_ADDR, ack);
		chk(ack, 1'b1);
		tri_w(1'b0, 1'b1, 1'b0, 1'b1, r, c, $random(seed));
		mcu.i2c_stop();
		exp_ack = 1'b0;
		foreach (bad[i]) begin
			mcu.i2c_start();
			mcu.i2c_byte(bad[i], ack);
			chk(ack, 1'b0);
			tri_w(1'b0, 1'b1, 1'b0, 1'b0, r, c, $random(seed));
			mcu.i2c_stop();
		end
		rb();
		$display("i2c test done");
	endtask
	// ------------------------------------------------------------
	// main sequence and watchdog
	// ------------------------------------------------------------
	initial begin
		hsync_in = 1'b0;
		rd_req = 1'b0;
		rd_row = 5'h00;
		rd_col = 5'h00;
		use_i2c = 1'b0;
		exp_ack = 1'b1;
		repeat (6) @(negedge clk);
		rst_b = 1'b1;
		repeat (6) @(negedge clk);
		chk({pkt_active, wr_commit, sda_oe, i2c_mode, pkt_format}, 6'h00);
		$display("reset test done");
		t_hs();
		repeat (2) t_ab();
		t_c(1'b0, OSW_LAST_ROW, 5'h1B);
		t_c(1'b1, 5'({$random(seed)} % 14), 5'h1B);
		t_hold();
		t_i2c();
		wrap_up();
	end
	// whole run needs well under half a millisecond
	initial begin
		#500_000;
		error_cnt++;
		wrap_up();
	end
endmodule
`default_nettype wire
